// file: tcc_defs.svh
// constants of the timer capture, control and status block
// assumes a register index taken from paddr[7:2] of a 32-bit APB
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define TCC_IDX_CAPA_HI 6'h20
`define TCC_IDX_CAPA_LO 6'h21
`define TCC_IDX_CAPB_HI 6'h24
`define TCC_IDX_CAPB_LO 6'h25
`define TCC_IDX_CNT_HI 6'h28
`define TCC_IDX_CNT_LO 6'h29
`define TCC_IDX_ALT_HI 6'h2A
`define TCC_IDX_ALT_LO 6'h2B
`define TCC_IDX_CTRL1 6'h2C
`define TCC_IDX_CTRL2 6'h2D
`define TCC_IDX_FLAGS 6'h2E

// ==========================================================
// bit positions of timer_control_primary
`define TCC_C1_CAP_IE_A 7
`define TCC_C1_CAP_IE_B 6
`define TCC_C1_CMP_IE_A 5
`define TCC_C1_OVF_IE 4
`define TCC_C1_CMP_OE_A 3
`define TCC_C1_EDGE_A 2
`define TCC_C1_EDGE_B 1
`define TCC_C1_LVL_A 0

// ==========================================================
// bit positions of timer_control_secondary
`define TCC_C2_CMP_IE_B 5
`define TCC_C2_CMP_OE_B 3
`define TCC_C2_LVL_B 0

// ==========================================================
// bit positions of timer_flags
`define TCC_F_CAP_A 7
`define TCC_F_CAP_B 6
`define TCC_F_CMP_A 5
`define TCC_F_OVF 4
`define TCC_F_PIN_A 3
`define TCC_F_PIN_B 2
`define TCC_F_CMP_B 1

// ==========================================================
// counter values
`define TCC_CNT_RELOAD 16'hFFFC
`define TCC_CNT_MAX 16'hFFFF
`define TCC_CNT_INC 16'h0001
`define TCC_CAP_CLEAR 16'h0000
`define TCC_PRE_LAST 2'h3
`define TCC_PRE_INC 2'h1
`define TCC_PRE_ZERO 2'h0
`define TCC_FILL_DONE 2'h3
`define TCC_FILL_INC 2'h1
`define TCC_BYTE_ZERO 8'h00
`define TCC_PAD_ZERO 24'h000000

`endif

// file: tcc_pkg.sv
// types of the timer capture, control and status block
// assumes tcc_defs.svh supplies the numeric constants
package tcc_pkg;

	// ==========================================================
	// state of the main block, index 0 is channel a
	typedef struct packed {
		logic [1:0] prescale;
		logic [15:0] count;
		logic [15:0] hist0;
		logic [15:0] hist1;
		logic [1:0][15:0] cap;
		logic [1:0][15:0] pend_data;
		logic [1:0] pend;
		logic [1:0] inhibit;
		logic [1:0] cap_ie;
		logic [1:0] cmp_ie;
		logic ovf_ie;
		logic [1:0] cmp_oe;
		logic [1:0] edge_sel;
		logic [1:0] out_lvl;
		logic [1:0] lvl_reg;
		logic [1:0] pin_q;
		logic [1:0] cap_f;
		logic [1:0] cmp_f;
		logic ovf_f;
		logic [1:0] arm_cap;
		logic [1:0] arm_cmp;
		logic arm_ovf;
		logic [7:0] cnt_buf;
		logic cnt_buf_v;
		logic stop_q;
		logic [31:0] prdata;
	} tcc_state_type;

	// ==========================================================
	// state of one pin synchroniser and edge detector
	typedef struct packed {
		logic meta;
		logic level;
		logic level_prev;
		logic [1:0] fill;
	} tcc_edge_state_type;

endpackage

// file: tcc_edge_sync.sv
// one capture pin: two-stage synchroniser and selectable edge detector
// assumes pin is asynchronous to ref_clk, edge_select from ref_clk logic
`timescale 1ns/100ps
`include "tcc_defs.svh"

module tcc_edge_sync
	import tcc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// pin side
	input wire logic pin,
	input wire logic edge_select,
	// block side
	output logic level,
	output logic edge_hit
);

	// ==========================================================
	// state
	tcc_edge_state_type s_q;
	tcc_edge_state_type s_d;

	always_comb begin
		s_d = s_q;
		s_d.meta = pin;
		s_d.level = s_q.meta;
		s_d.level_prev = s_q.level;
		s_d.fill = (s_q.fill == `TCC_FILL_DONE) ? s_q.fill : s_q.fill + `TCC_FILL_INC;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// fill guard: level_prev holds a real pin level only after three loads, so no false edge after reset
	assign level = s_q.level;
	assign edge_hit = (s_q.fill == `TCC_FILL_DONE) && (s_q.level != s_q.level_prev) && (s_q.level == edge_select);

	// ==========================================================
	// checks
	a_edge_after_sync: assert property (@(posedge ref_clk) disable iff (!nrst)
		edge_hit && $stable(edge_select) |-> ($past(pin, 2) == edge_select) && ($past(pin, 3) != edge_select))
		else $error("edge seen without two-stage synchronised pin change");

endmodule

// file: tcc_timer.sv
// timer capture channels, control registers, status flags and counter
// assumes an APB master on ref_clk; comparators sit outside and send match strobes
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`include "tcc_defs.svh"

// Function
// - capture register loads count on the pin edge chosen by edge select
// - captured value is count before the edge plus one
// - capture happens whether or not the capture flag is set
// - reading capture high byte blocks captures until low byte is read
// - reading only the capture low byte never blocks captures
// - capture flag with its enable requests an interrupt
// - reset keeps capture data except when leaving stop
// - primary control layout; reset clears upper five bits only
// - compare output held low unless its output enable is set
// - compare match loads output level bit into the pin level register
// - secondary control holds compare b enable, output enable, level; rest zero
// - status register is read-only with fixed flag and pin layout
// - capture flag sets on edge, clears by status then capture low access
// - compare flag sets on match, clears by status then compare low access
// - overflow flag sets on wrap, clears by status then counter low access
// - status shows present capture pin levels
// - alternate counter reads same count, never clears overflow flag
// - wait mode leaves counting, capture and compare running
// - stop halts counter; reset forces reload value
// - edge in stop arms capture, flag and data appear on wake
// - reset out of stop discards capture edges seen in stop
// - counter advances once every four clocks
module tcc_timer
	import tcc_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// chip state
	input wire logic system_reset,
	input wire logic stop_mode,
	// capture pins
	input wire logic capture_pin_a,
	input wire logic capture_pin_b,
	// external comparators
	input wire logic compare_match_a,
	input wire logic compare_match_b,
	input wire logic compare_low_access_a,
	input wire logic compare_low_access_b,
	// counter and outputs
	output logic [15:0] count,
	output logic compare_pin_a,
	output logic compare_pin_b,
	output logic timer_irq
);

	// ==========================================================
	// decode helpers
	function automatic logic tcc_hit(input logic a, input logic [5:0] i, input logic [5:0] t);
		return a && (i == t);
	endfunction

	function automatic logic tcc_mapped(input logic [5:0] i);
		logic m;
		m = 1'b0;
		case (i)
			`TCC_IDX_CAPA_HI, `TCC_IDX_CAPA_LO, `TCC_IDX_CAPB_HI, `TCC_IDX_CAPB_LO,
			`TCC_IDX_CNT_HI, `TCC_IDX_CNT_LO, `TCC_IDX_ALT_HI, `TCC_IDX_ALT_LO,
			`TCC_IDX_CTRL1, `TCC_IDX_CTRL2, `TCC_IDX_FLAGS: begin
				m = 1'b1;
			end
			default: begin
				m = 1'b0;
			end
		endcase
		return m;
	endfunction

	// ==========================================================
	// state and bus terms
	tcc_state_type st;
	tcc_state_type n;
	logic [5:0] idx;
	logic acc;
	logic acc_rd;
	logic acc_wr;
	logic acc_status;
	logic [1:0] acc_cap_hi;
	logic [1:0] acc_cap_lo;
	logic [1:0] cmp_lo;
	logic [1:0] cmp_match;
	logic [1:0] pin_level;
	logic [1:0] edge_evt;
	logic [1:0] cap_pin;
	logic [1:0] cap_set;
	logic [1:0] cmp_set;
	logic ovf_set;
	logic tick;
	logic wake;
	logic [7:0] rd_byte;

	assign idx = paddr[7:2];
	// zero wait states: every access phase completes at once
	assign acc = psel && penable;
	assign acc_rd = acc && !pwrite;
	assign acc_wr = acc && pwrite;
	assign acc_status = tcc_hit(acc, idx, `TCC_IDX_FLAGS);
	assign acc_cap_hi = {tcc_hit(acc_rd, idx, `TCC_IDX_CAPB_HI), tcc_hit(acc_rd, idx, `TCC_IDX_CAPA_HI)};
	assign acc_cap_lo = {tcc_hit(acc, idx, `TCC_IDX_CAPB_LO), tcc_hit(acc, idx, `TCC_IDX_CAPA_LO)};
	assign cmp_lo = {compare_low_access_b, compare_low_access_a};
	assign cmp_match = {compare_match_b, compare_match_a};
	assign cap_pin = {capture_pin_b, capture_pin_a};
	assign wake = st.stop_q && !stop_mode && !system_reset;

	// ==========================================================
	// capture pin front ends
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_pin
			tcc_edge_sync u_sync (
				.ref_clk(ref_clk),
				.nrst(nrst),
				.pin(cap_pin[g]),
				.edge_select(st.edge_sel[g]),
				.level(pin_level[g]),
				.edge_hit(edge_evt[g])
			);
		end
	endgenerate

	// ==========================================================
	// next state
	always_comb begin
		n = st;
		rd_byte = `TCC_BYTE_ZERO;
		cap_set = 2'h0;
		cmp_set = {compare_match_b, compare_match_a};
		ovf_set = 1'b0;
		tick = 1'b0;

		// read mux, sampled in the setup cycle
		case (idx)
			`TCC_IDX_CAPA_HI: rd_byte = st.cap[0][15:8];
			`TCC_IDX_CAPA_LO: rd_byte = st.cap[0][7:0];
			`TCC_IDX_CAPB_HI: rd_byte = st.cap[1][15:8];
			`TCC_IDX_CAPB_LO: rd_byte = st.cap[1][7:0];
			`TCC_IDX_CNT_HI, `TCC_IDX_ALT_HI: rd_byte = st.count[15:8];
			`TCC_IDX_CNT_LO, `TCC_IDX_ALT_LO: rd_byte = st.cnt_buf_v ? st.cnt_buf : st.count[7:0];
			`TCC_IDX_CTRL1: begin
				rd_byte[`TCC_C1_CAP_IE_A] = st.cap_ie[0];
				rd_byte[`TCC_C1_CAP_IE_B] = st.cap_ie[1];
				rd_byte[`TCC_C1_CMP_IE_A] = st.cmp_ie[0];
				rd_byte[`TCC_C1_OVF_IE] = st.ovf_ie;
				rd_byte[`TCC_C1_CMP_OE_A] = st.cmp_oe[0];
				rd_byte[`TCC_C1_EDGE_A] = st.edge_sel[0];
				rd_byte[`TCC_C1_EDGE_B] = st.edge_sel[1];
				rd_byte[`TCC_C1_LVL_A] = st.out_lvl[0];
			end
			`TCC_IDX_CTRL2: begin
				rd_byte[`TCC_C2_CMP_IE_B] = st.cmp_ie[1];
				rd_byte[`TCC_C2_CMP_OE_B] = st.cmp_oe[1];
				rd_byte[`TCC_C2_LVL_B] = st.out_lvl[1];
			end
			`TCC_IDX_FLAGS: begin
				rd_byte[`TCC_F_CAP_A] = st.cap_f[0];
				rd_byte[`TCC_F_CAP_B] = st.cap_f[1];
				rd_byte[`TCC_F_CMP_A] = st.cmp_f[0];
				rd_byte[`TCC_F_OVF] = st.ovf_f;
				rd_byte[`TCC_F_PIN_A] = pin_level[0];
				rd_byte[`TCC_F_PIN_B] = pin_level[1];
				rd_byte[`TCC_F_CMP_B] = st.cmp_f[1];
			end
			default: rd_byte = `TCC_BYTE_ZERO;
		endcase
		if (psel && !penable) begin
			n.prdata = {`TCC_PAD_ZERO, rd_byte};
		end

		// control writes
		if (tcc_hit(acc_wr, idx, `TCC_IDX_CTRL1)) begin
			n.cap_ie[0] = pwdata[`TCC_C1_CAP_IE_A];
			n.cap_ie[1] = pwdata[`TCC_C1_CAP_IE_B];
			n.cmp_ie[0] = pwdata[`TCC_C1_CMP_IE_A];
			n.ovf_ie = pwdata[`TCC_C1_OVF_IE];
			n.cmp_oe[0] = pwdata[`TCC_C1_CMP_OE_A];
			n.edge_sel[0] = pwdata[`TCC_C1_EDGE_A];
			n.edge_sel[1] = pwdata[`TCC_C1_EDGE_B];
			n.out_lvl[0] = pwdata[`TCC_C1_LVL_A];
		end
		if (tcc_hit(acc_wr, idx, `TCC_IDX_CTRL2)) begin
			n.cmp_ie[1] = pwdata[`TCC_C2_CMP_IE_B];
			n.cmp_oe[1] = pwdata[`TCC_C2_CMP_OE_B];
			n.out_lvl[1] = pwdata[`TCC_C2_LVL_B];
		end

		// counter keeps running in wait, halts only in stop
		if (!stop_mode) begin
			n.prescale = st.prescale + `TCC_PRE_INC;
			tick = (st.prescale == `TCC_PRE_LAST);
		end
		if (tick) begin
			n.count = st.count + `TCC_CNT_INC;
			ovf_set = (st.count == `TCC_CNT_MAX);
		end
		// history lines the count up with the synchroniser delay
		n.hist0 = st.count;
		n.hist1 = st.hist0;
		n.stop_q = stop_mode;

		// counter low byte buffer; hist0 holds the count shown in the setup cycle
		if ((tcc_hit(acc_rd, idx, `TCC_IDX_CNT_HI) || tcc_hit(acc_rd, idx, `TCC_IDX_ALT_HI)) && !st.cnt_buf_v) begin
			n.cnt_buf = st.hist0[7:0];
			n.cnt_buf_v = 1'b1;
		end
		if (tcc_hit(acc_rd, idx, `TCC_IDX_CNT_LO) || tcc_hit(acc_rd, idx, `TCC_IDX_ALT_LO)) begin
			n.cnt_buf_v = 1'b0;
		end

		for (int i = 0; i < 2; i++) begin
			// capture and stop-mode arming
			if (edge_evt[i]) begin
				if (stop_mode) begin
					if (!st.pend[i]) begin
						n.pend[i] = 1'b1;
						n.pend_data[i] = st.hist1 + `TCC_CNT_INC;
					end
				end else begin
					cap_set[i] = 1'b1;
					if (!st.inhibit[i]) begin
						n.cap[i] = st.hist1 + `TCC_CNT_INC;
					end
				end
			end
			if (wake && st.pend[i]) begin
				cap_set[i] = 1'b1;
				n.cap[i] = st.pend_data[i];
				n.pend[i] = 1'b0;
			end
			if (acc_cap_hi[i]) begin
				n.inhibit[i] = 1'b1;
			end
			if (acc_cap_lo[i] && !pwrite) begin
				n.inhibit[i] = 1'b0;
			end

			// capture flag: arm on status access, clear on low byte, set wins
			if (acc_status && st.cap_f[i]) begin
				n.arm_cap[i] = 1'b1;
			end
			if (st.arm_cap[i] && acc_cap_lo[i]) begin
				n.cap_f[i] = 1'b0;
				n.arm_cap[i] = 1'b0;
			end
			if (cap_set[i]) begin
				n.cap_f[i] = 1'b1;
			end

			// compare flag and output level register
			if (acc_status && st.cmp_f[i]) begin
				n.arm_cmp[i] = 1'b1;
			end
			if (st.arm_cmp[i] && cmp_lo[i]) begin
				n.cmp_f[i] = 1'b0;
				n.arm_cmp[i] = 1'b0;
			end
			if (cmp_set[i]) begin
				n.cmp_f[i] = 1'b1;
			end
			if (cmp_match[i]) begin
				n.lvl_reg[i] = st.out_lvl[i];
			end
		end

		// overflow flag; only the main counter low byte clears it
		if (acc_status && st.ovf_f) begin
			n.arm_ovf = 1'b1;
		end
		if (st.arm_ovf && tcc_hit(acc, idx, `TCC_IDX_CNT_LO)) begin
			n.ovf_f = 1'b0;
			n.arm_ovf = 1'b0;
		end
		if (ovf_set) begin
			n.ovf_f = 1'b1;
		end

		// chip reset: edge selects and levels survive, capture data too unless in stop
		if (system_reset) begin
			n.cap_ie = 2'h0;
			n.cmp_ie = 2'h0;
			n.ovf_ie = 1'b0;
			n.cmp_oe = 2'h0;
			n.ovf_f = 1'b0;
			n.arm_ovf = 1'b0;
			n.count = `TCC_CNT_RELOAD;
			n.prescale = `TCC_PRE_ZERO;
			n.inhibit = 2'h0;
			n.cnt_buf_v = 1'b0;
			n.pend = 2'h0;
			if (stop_mode) begin
				n.cap = {`TCC_CAP_CLEAR, `TCC_CAP_CLEAR};
				n.cap_f = 2'h0;
				n.arm_cap = 2'h0;
			end
		end

		// pins registered so they never glitch on enable changes
		n.pin_q = n.cmp_oe & n.lvl_reg;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
			st.count <= `TCC_CNT_RELOAD;
		end else begin
			st <= n;
		end
	end

	// ==========================================================
	// outputs
	assign prdata = st.prdata;
	assign pready = 1'b1;
	assign pslverr = acc && !tcc_mapped(idx);
	assign count = st.count;
	assign compare_pin_a = st.pin_q[0];
	assign compare_pin_b = st.pin_q[1];
	assign timer_irq = |(st.cap_f & st.cap_ie) || |(st.cmp_f & st.cmp_ie) || (st.ovf_f && st.ovf_ie);

	// ==========================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence s_arm_cap_a;
		acc_status && st.cap_f[0];
	endsequence

	sequence s_low_cap_a;
		acc_cap_lo[0] && !cap_set[0] && !system_reset;
	endsequence

	a_capture_load_value: assert property (
		edge_evt[0] && !stop_mode && !st.inhibit[0] && !system_reset |=> st.cap[0] == $past(st.hist1) + `TCC_CNT_INC)
		else $error("capture a did not load count plus one");

	a_capture_hold_inhibit: assert property (
		st.inhibit[0] && !st.stop_q && !system_reset |=> $stable(st.cap[0]))
		else $error("capture a changed while inhibited");

	a_high_read_blocks: assert property (
		acc_cap_hi[0] && !system_reset |=> st.inhibit[0])
		else $error("high byte read did not block captures");

	a_low_read_frees: assert property (
		acc_cap_lo[0] && acc_rd && !system_reset |=> !st.inhibit[0])
		else $error("low byte read did not free captures");

	a_low_read_free: assert property (
		!st.inhibit[0] && acc_cap_lo[0] |=> !st.inhibit[0])
		else $error("low byte read blocked captures");

	a_capture_irq: assert property (
		cap_set[0] && st.cap_ie[0] && !system_reset |=> timer_irq)
		else $error("capture a with enable gave no interrupt");

	a_flag_clear_seq: assert property (
		s_arm_cap_a ##[2:8] s_low_cap_a |=> !st.cap_f[0])
		else $error("capture a flag survived its clearing sequence");

	a_flag_needs_arm: assert property (
		st.cap_f[0] && !st.arm_cap[0] && !(system_reset && stop_mode) |=> st.cap_f[0])
		else $error("capture a flag cleared without status access");

	a_compare_level: assert property (
		compare_match_a && !system_reset |=> compare_pin_a == (st.cmp_oe[0] && $past(st.out_lvl[0])))
		else $error("compare a pin did not take output level");

	a_overflow_set: assert property (
		tick && st.count == `TCC_CNT_MAX && !system_reset |=> st.ovf_f && st.count == `TCC_CAP_CLEAR)
		else $error("wrap did not set overflow flag");

	a_alt_keeps_ovf: assert property (
		st.ovf_f && tcc_hit(acc, idx, `TCC_IDX_ALT_LO) && !system_reset |=> st.ovf_f)
		else $error("alternate counter read cleared overflow flag");

	a_counter_rate: assert property (
		!stop_mode && !system_reset && st.prescale == `TCC_PRE_LAST ##1 !stop_mode && !system_reset [*3]
		|=> $past(st.count, 4) + `TCC_CNT_INC == st.count)
		else $error("counter did not advance once per four clocks");

	a_stop_holds_count: assert property (
		stop_mode && !system_reset |=> $stable(st.count))
		else $error("counter moved in stop");

	a_reset_reload: assert property (
		system_reset |=> st.count == `TCC_CNT_RELOAD)
		else $error("reset did not reload counter");

	a_stop_no_flag: assert property (
		stop_mode && !st.cap_f[0] |=> !st.cap_f[0])
		else $error("capture flag set during stop");

	a_stop_reset_discard: assert property (
		system_reset && stop_mode |=> !st.cap_f[0] && !st.pend[0] && st.cap[0] == `TCC_CAP_CLEAR)
		else $error("capture edge in stop survived reset");

endmodule

// file: tcc_pin_src.sv
// far side of the capture pins: two digital signal sources
// assumes the bench sets the wanted levels; edges land off the sampling edge
`timescale 1ns/100ps

// ==========================================================
// pin sources
module tcc_pin_src (
	// clock
	input wire logic ref_clk,
	// wanted levels, bit 0 is pin a
	input wire logic [1:0] want,
	// capture pins
	output logic pin_a,
	output logic pin_b
);
	initial begin
		pin_a = 1'h1;
		pin_b = 1'h1;
	end
	// falling edge keeps source edges away from the sampling edge
	always @(negedge ref_clk) begin
		pin_a <= want[0];
		pin_b <= want[1];
	end
endmodule

// file: timer_capture_control_status_tb_top.sv
// self-checking bench of the timer capture, control and status block
// assumes tcc_defs.svh, tcc_pkg and the pin source model are compiled first
`timescale 1ns/100ps

module timer_capture_control_status_tb_top;
	import tcc_pkg::*;
	typedef struct {logic wr; logic [7:0] a; logic [7:0] wd; logic [7:0] exp; logic [7:0] mask; logic err;} tcc_row_type;
	logic ref_clk = 1'h0;
	logic nrst = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, pin_a, pin_b, timer_irq;
	logic system_reset = 1'h0;
	logic stop_mode = 1'h0;
	logic [1:0] want = 2'h3;
	logic [1:0] match = 2'h0;
	logic [1:0] low = 2'h0;
	logic [1:0] cmp;
	logic [15:0] count, c0, e, v16;
	logic [7:0] v;
	logic er;
	int mismatches = 0;
	int check_count = 0;
	int cyc = 0;
	tcc_row_type rows[11] = '{
		'{1'h0, 8'hB0, 8'h00, 8'h00, 8'hFF, 1'h0}, '{1'h0, 8'hB4, 8'h00, 8'h00, 8'hFF, 1'h0},
		'{1'h0, 8'hB8, 8'h00, 8'h0C, 8'hEF, 1'h0}, '{1'h1, 8'hB0, 8'hFF, 8'h00, 8'h00, 1'h0},
		'{1'h0, 8'hB0, 8'h00, 8'hFF, 8'hFF, 1'h0}, '{1'h1, 8'hB4, 8'hFF, 8'h00, 8'h00, 1'h0},
		'{1'h0, 8'hB4, 8'h00, 8'h29, 8'hFF, 1'h0}, '{1'h1, 8'hB8, 8'hFF, 8'h00, 8'h00, 1'h0},
		'{1'h0, 8'hB8, 8'h00, 8'h0C, 8'hEF, 1'h0}, '{1'h0, 8'h00, 8'h00, 8'h00, 8'hFF, 1'h1},
		'{1'h1, 8'h00, 8'h5A, 8'h00, 8'h00, 1'h1}};

	always #5 ref_clk = ~ref_clk;

	tcc_timer dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.system_reset(system_reset), .stop_mode(stop_mode), .capture_pin_a(pin_a), .capture_pin_b(pin_b),
		.compare_match_a(match[0]), .compare_match_b(match[1]), .compare_low_access_a(low[0]),
		.compare_low_access_b(low[1]), .count(count), .compare_pin_a(cmp[0]), .compare_pin_b(cmp[1]),
		.timer_irq(timer_irq));

	tcc_pin_src src (.ref_clk(ref_clk), .want(want), .pin_a(pin_a), .pin_b(pin_b));

	// ==========================================================
	// shared tasks
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// waits on pready; only the cycle ceiling ends a hang
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, wd};
		@(posedge ref_clk);
		penable <= 1'h1;
		do @(posedge ref_clk); while (pready !== 1'h1);
		er = pslverr;
		v = prdata[7:0];
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic rcap(input int ch);
		apb(1'h0, ch ? 8'h90 : 8'h80, 8'h00);
		v16[15:8] = v;
		apb(1'h0, ch ? 8'h94 : 8'h84, 8'h00);
		v16[7:0] = v;
	endtask

	// count seen in the cycle before the sampling edge, plus one
	task automatic pin_edge(input int ch, input logic lvl);
		@(posedge ref_clk);
		want[ch] <= lvl;
		@(negedge ref_clk);
		c0 = count;
		e = c0 + 16'h0001;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic pulse(input int ch, input logic m);
		@(posedge ref_clk);
		if (m) match[ch] <= 1'h1;
		else low[ch] <= 1'h1;
		@(posedge ref_clk);
		match <= 2'h0;
		low <= 2'h0;
		repeat (2) @(posedge ref_clk);
	endtask

	task automatic sys_reset();
		@(posedge ref_clk);
		system_reset <= 1'h1;
		@(posedge ref_clk);
		system_reset <= 1'h0;
		@(negedge ref_clk);
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (8) @(posedge ref_clk);
		nrst <= 1'h1;
		repeat (2) @(posedge ref_clk);
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].wd);
			if (!rows[i].wr) chk(v & rows[i].mask, rows[i].exp);
			chk(er, rows[i].err);
		end
		$display("register table done");
		for (int ch = 0; ch < 2; ch++) begin
			apb(1'h1, 8'hB0, ch ? 8'h40 : 8'h80);
			pin_edge(ch, 1'h0);
			apb(1'h0, 8'hB8, 8'h00);
			chk(v[7 - ch], 1'h1);
			chk(v[3 - ch], 1'h0);
			chk(timer_irq, 1'h1);
			rcap(ch);
			chk(v16, e);
			apb(1'h0, 8'hB8, 8'h00);
			chk(v[7 - ch], 1'h0);
			chk(timer_irq, 1'h0);
		end
		$display("capture done");
		apb(1'h1, 8'hB0, 8'h04);
		rcap(0);
		apb(1'h0, 8'h80, 8'h00);
		chk(v, v16[15:8]);
		pin_edge(0, 1'h1);
		apb(1'h0, 8'h84, 8'h00);
		chk(v, v16[7:0]);
		apb(1'h0, 8'h84, 8'h00);
		pin_edge(0, 1'h0);
		pin_edge(0, 1'h1);
		rcap(0);
		chk(v16, e);
		$display("inhibit done");
		for (int ch = 0; ch < 2; ch++) begin
			apb(1'h1, ch ? 8'hB4 : 8'hB0, 8'h09);
			pulse(ch, 1'h1);
			chk(cmp[ch], 1'h1);
			apb(1'h0, 8'hB8, 8'h00);
			chk(v[ch ? 1 : 5], 1'h1);
			apb(1'h1, ch ? 8'hB4 : 8'hB0, 8'h08);
			pulse(ch, 1'h1);
			chk(cmp[ch], 1'h0);
			apb(1'h1, ch ? 8'hB4 : 8'hB0, 8'h09);
			pulse(ch, 1'h1);
			apb(1'h1, ch ? 8'hB4 : 8'hB0, 8'h01);
			@(negedge ref_clk);
			chk(cmp[ch], 1'h0);
			apb(1'h0, 8'hB8, 8'h00);
			pulse(ch, 1'h0);
			apb(1'h0, 8'hB8, 8'h00);
			chk(v[ch ? 1 : 5], 1'h0);
		end
		$display("compare done");
		apb(1'h1, 8'hB0, 8'hFF);
		apb(1'h1, 8'hB4, 8'hFF);
		rcap(0);
		sys_reset();
		chk(count, 16'hFFFC);
		apb(1'h0, 8'hB0, 8'h00);
		chk(v, 8'h07);
		apb(1'h0, 8'hB4, 8'h00);
		chk(v, 8'h01);
		apb(1'h0, 8'hB8, 8'h00);
		chk(v[4], 1'h0);
		e = v16;
		rcap(0);
		chk(v16, e);
		repeat (20) @(posedge ref_clk);
		apb(1'h0, 8'hB8, 8'h00);
		chk(v[4], 1'h1);
		apb(1'h0, 8'hAC, 8'h00);
		apb(1'h0, 8'hB8, 8'h00);
		chk(v[4], 1'h1);
		apb(1'h0, 8'hA4, 8'h00);
		apb(1'h0, 8'hB8, 8'h00);
		chk(v[4], 1'h0);
		@(negedge ref_clk);
		c0 = count;
		repeat (40) @(negedge ref_clk);
		chk(count - c0, 16'h000A);
		$display("reset and overflow done");
		apb(1'h0, 8'h84, 8'h00);
		stop_mode <= 1'h1;
		repeat (2) @(negedge ref_clk);
		c0 = count;
		repeat (8) @(negedge ref_clk);
		chk(count, c0);
		e = c0 + 16'h0001;
		pin_edge(0, 1'h0);
		pin_edge(0, 1'h1);
		apb(1'h0, 8'hB8, 8'h00);
		chk(v[7], 1'h0);
		stop_mode <= 1'h0;
		repeat (4) @(posedge ref_clk);
		apb(1'h0, 8'hB8, 8'h00);
		chk(v[7], 1'h1);
		rcap(0);
		chk(v16, e);
		stop_mode <= 1'h1;
		pin_edge(0, 1'h0);
		pin_edge(0, 1'h1);
		sys_reset();
		@(posedge ref_clk);
		stop_mode <= 1'h0;
		repeat (4) @(posedge ref_clk);
		apb(1'h0, 8'hB8, 8'h00);
		chk(v[7], 1'h0);
		rcap(0);
		chk(v16, 16'h0000);
		$display("stop done");
		end_of_test();
	end
endmodule
